// *** tb/i2c_master_model.sv ***
// Two-wire bus master that makes every clock pulse and bus condition
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // Clock for phase timing
   input  wire logic mclk,
   // Slave pull-down and resolved bus lines
   input  wire logic sda_oe,
   output var logic  scl,
   output wire logic sda
);
   logic m_oe;
   int   half;

   // Pull-up wins unless either party pulls low
   assign sda = !(sda_oe | m_oe);

   // Bus idles with both lines high
   initial
   begin
      scl = 1'b1;
      m_oe = 1'b0;
      half = 20;
   end

   // One phase of the bus clock, changes land just after an edge
   task tick();
      repeat (half) @(posedge mclk);
      #1;
   endtask

   // Start or repeated start: data falls while clock is high
   task start();
      tick();
      m_oe = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      m_oe = 1'b1;
      tick();
      scl = 1'b0;
   endtask

   // Stop: data rises while clock is high
   task stop();
      tick();
      m_oe = 1'b1;
      tick();
      scl = 1'b1;
      tick();
      m_oe = 1'b0;
      tick();
   endtask

   // One bit: data set in clock low, sampled at the end of clock high
   task bit_io(input logic b, output logic r);
      tick();
      m_oe = !b;
      tick();
      scl = 1'b1;
      tick();
      r = sda;
      scl = 1'b0;
   endtask

   // Byte out, most significant bit first, then the acknowledge pulse
   task wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   // Byte in, then acknowledge unless it is the last one
   task rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule // i2c_master_model
`default_nettype wire

// *** tb/rtc_ctrl_status_assertions.sv ***
// Concurrent checks on the pins of the clock control and serial slave block
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_status_checker #(
   parameter int OSC_WATCH = 200
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Crystal and alarm inputs
   input wire logic xtal_clk,
   input wire logic alarm_one_match,
   input wire logic alarm_two_match,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Oscillator and interrupt outputs
   input wire logic osc_run,
   input wire logic irq_out_first_n,
   input wire logic square_or_irq_second_n
);
   // All checks sample on the system clock and sleep during reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   chk_sda_never_high: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   chk_reset_osc_on: assert property ($fell(srst) |-> osc_run)
      else $error("oscillator off after reset");
   chk_reset_irq_idle: assert property ($fell(srst) |-> irq_out_first_n && !sda_oe)
      else $error("interrupt or data drive active after reset");
   chk_oe_moves_low: assert property ($changed(sda_oe)
      |-> !scl_in && !$past(scl_in, 2) && $past(scl_in, 8))
      else $error("data drive changed outside the clock low phase");
   chk_ack_held_high: assert property (sda_oe && $rose(scl_in) |-> sda_oe [*8])
      else $error("low data not held through clock high");
   chk_start_no_drive: assert property (scl_in && $fell(sda_in) |=> !sda_oe [*6])
      else $error("slave drove data right after start");
   chk_stop_released: assert property (scl_in && $rose(sda_in) |=> !sda_oe [*8])
      else $error("slave drove data after stop");
   chk_ctrl_on_ack: assert property ($changed(osc_run) |-> ##[0:3] sda_oe)
      else $error("control changed away from a data acknowledge");

   // Main scenarios
   cov_ack_seen: cover property ($rose(sda_oe));
   cov_osc_stop: cover property ($fell(osc_run));
   cov_start_seen: cover property (scl_in && $fell(sda_in));
endmodule // rtc_ctrl_status_checker

bind rtc_ctrl_status rtc_ctrl_status_checker #(.OSC_WATCH(OSC_WATCH)) chk (
   .mclk(mclk), .srst(srst), .xtal_clk(xtal_clk),
   .alarm_one_match(alarm_one_match), .alarm_two_match(alarm_two_match),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .osc_run(osc_run), .irq_out_first_n(irq_out_first_n),
   .square_or_irq_second_n(square_or_irq_second_n)
);
`default_nettype wire

// *** tb/rtc_ctrl_status_test.sv ***
// Self-checking bench of the clock control, status and serial slave block
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl_status_test;
   localparam logic [7:0] WR = {rtc_ctrl_pkg::SLAVE_ADDR, 1'b0};
   localparam logic [7:0] RD = {rtc_ctrl_pkg::SLAVE_ADDR, 1'b1};
   typedef struct packed {
      logic [7:0] wr;
      logic [7:0] rd;
      logic       osc;
      logic [9:0] half;
   } row_t;
   logic       mclk, srst, xtal_clk, sda_out, sda_oe, osc_run, irq1_n, sq_n, k;
   wire  logic scl, sda;
   logic [7:0] q [3];
   int         fails, check_count, h;
   // Control value written, value read back, oscillator run, half period in mclk
   row_t rows [6] = '{
      '{8'h18, 8'h18, 1'b1, 10'h020}, '{8'h10, 8'h10, 1'b1, 10'h080},
      '{8'h08, 8'h08, 1'b1, 10'h100}, '{8'h00, 8'h00, 1'b1, 10'h000},
      '{8'hff, 8'h9f, 1'b0, 10'h000}, '{8'h7b, 8'h1b, 1'b1, 10'h020}};

   rtc_ctrl_status #(.OSC_WATCH(200)) dut (
      .mclk(mclk), .srst(srst), .xtal_clk(xtal_clk),
      .alarm_one_match(1'b0), .alarm_two_match(1'b0),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .osc_run(osc_run), .irq_out_first_n(irq1_n), .square_or_irq_second_n(sq_n));
   i2c_master_model mst (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   // System clock and a crystal that stalls while the oscillator is off
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial
   begin
      xtal_clk = 1'b0;
      #37;
      forever
      begin
         #80;
         if (osc_run !== 1'b0) xtal_clk = ~xtal_clk;
      end
   end

   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task send(input logic [7:0] d);
      logic a;
      mst.wr_byte(d, a);
      check("ack", 8'h01, {7'h00, a});
   endtask

   task reg_wr(input logic [7:0] a, input logic [7:0] d);
      mst.start();
      send(WR);
      send(a);
      send(d);
      mst.stop();
   endtask

   // Pointer write, repeated start, then n bytes with the last one refused
   task reg_rd(input logic [7:0] a, input int n, output logic [7:0] r [3]);
      mst.start();
      send(WR);
      send(a);
      mst.start();
      send(RD);
      for (int i = 0; i < n; i++) mst.rd_byte(i == n - 1, r[i]);
      mst.stop();
   endtask

   // Length of one full level of the square output, 0 if it sits still
   task measure(output int hp);
      int   n;
      logic s;
      hp = 0;
      for (int j = 0; j < 2; j++)
      begin
         s = sq_n;
         n = 0;
         while (sq_n === s && n < 600)
         begin
            @(posedge mclk);
            n++;
         end
      end
      if (n < 600) hp = n;
   endtask

   task end_of_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      srst = 1'b1;
      fails = 0;
      check_count = 0;
      repeat (160) @(posedge mclk);
      #1 srst = 1'b0;
      repeat (4) @(posedge mclk);
      reg_rd(8'h0e, 2, q);
      check("ctrl reset", rtc_ctrl_pkg::CTRL_RESET, q[0]);
      check("status reset", 8'h80, q[1]);
      check("osc_run", 8'h01, {7'h00, osc_run});
      $display("test reset done");
      foreach (rows[i])
      begin
         reg_wr(8'h0e, rows[i].wr);
         reg_rd(8'h0e, 1, q);
         check("ctrl", rows[i].rd, q[0]);
         check("osc_run", {7'h00, rows[i].osc}, {7'h00, osc_run});
         measure(h);
         check_count++;
         if (h > int'(rows[i].half) + 2 || h + 2 < int'(rows[i].half))
         begin
            fails++;
            $display("BAD half period expected %0d seen %0d", rows[i].half, h);
         end
      end
      $display("test rate table done");
      // Stop flag clears on zero, ones leave flags alone, a stop sets it again
      reg_wr(8'h0f, 8'h00);
      reg_rd(8'h0f, 1, q);
      check("flag clear", 8'h00, q[0]);
      reg_wr(8'h0f, 8'hff);
      reg_rd(8'h0f, 1, q);
      check("flags kept", 8'h00, q[0]);
      reg_wr(8'h0e, 8'h9b);
      repeat (300) @(posedge mclk);
      reg_wr(8'h0e, 8'h1b);
      repeat (300) @(posedge mclk);
      reg_rd(8'h0f, 1, q);
      check("flag after stop", 8'h80, q[0]);
      $display("test stop flag done");
      // Burst write through the pointer, then a read that wraps
      mst.start();
      send(WR);
      send(8'h0e);
      send(8'h04);
      send(8'h00);
      mst.stop();
      reg_rd(8'h0e, 3, q);
      check("burst ctrl", 8'h04, q[0]);
      check("burst status", 8'h00, q[1]);
      check("wrapped", 8'h00, q[2]);
      check("second out", 8'h01, {7'h00, sq_n});
      check("first out", 8'h01, {7'h00, irq1_n});
      $display("test burst done");
      // Unmapped place and a foreign address
      reg_wr(8'h05, 8'haa);
      reg_rd(8'h05, 1, q);
      check("unmapped", 8'h00, q[0]);
      mst.start();
      mst.wr_byte(8'ha0, k);
      check("foreign ack", 8'h00, {7'h00, k});
      mst.stop();
      $display("test refusal done");
      // Fast mode bit rate
      mst.half = 167;
      reg_rd(8'h0e, 1, q);
      check("fast read", 8'h04, q[0]);
      $display("test fast mode done");
      end_of_test();
   end
endmodule // rtc_ctrl_status_test
`default_nettype wire

// *** verilog/rtc_ctrl_pkg.sv ***
// Shared constants and types of the clock control, status and serial slave block
`default_nettype none
package rtc_ctrl_pkg;

   // Register map and slave address
   localparam logic [7:0] CTRL_OFFSET    = 8'h0e;
   localparam logic [7:0] STATUS_OFFSET  = 8'h0f;
   localparam logic [7:0] PTR_LAST       = 8'h0f;
   localparam logic [7:0] PTR_RESET      = 8'h00;
   localparam logic [6:0] SLAVE_ADDR     = 7'h68;

   // Control field positions
   localparam int CTRL_OSC_DIS_BIT  = 7;
   localparam int CTRL_RS_HI_BIT    = 4;
   localparam int CTRL_RS_LO_BIT    = 3;
   localparam int CTRL_ROUTE_BIT    = 2;
   localparam int CTRL_ALM2_EN_BIT  = 1;
   localparam int CTRL_ALM1_EN_BIT  = 0;
   localparam logic [7:0] CTRL_WR_MASK = 8'h9f;

   // Status field positions
   localparam int STAT_STOP_BIT     = 7;
   localparam int STAT_ALM2_BIT     = 1;
   localparam int STAT_ALM1_BIT     = 0;

   // Values after reset
   localparam logic [7:0] CTRL_RESET    = 8'h18;
   localparam logic       STOP_FLAG_RESET = 1'b1;

   // Square wave rate codes
   localparam logic [1:0] RATE_1HZ      = 2'h0;
   localparam logic [1:0] RATE_4K       = 2'h1;
   localparam logic [1:0] RATE_8K       = 2'h2;
   localparam logic [1:0] RATE_32K      = 2'h3;

   // Divider taps, oscillator clock is twice 32.768 kHz
   localparam int DIV_WIDTH         = 16;
   localparam int TAP_32K           = 0;
   localparam int TAP_8K            = 2;
   localparam int TAP_4K            = 3;
   localparam int TAP_1HZ           = 15;

   // Timing of the oscillator watchdog
   localparam int MCLK_PERIOD_NS    = 5;
   localparam int OSC_WATCH_NS      = 50000;
   localparam int OSC_WATCH_CYCLES  = OSC_WATCH_NS / MCLK_PERIOD_NS;

   // Serial bit counter values
   localparam logic [3:0] BIT_LAST      = 4'h7;
   localparam logic [3:0] BIT_FULL      = 4'h8;

   // Control register layout
   typedef struct packed {
      logic       osc_disable_n;
      logic [1:0] unused;
      logic       rate_select_hi;
      logic       rate_select_lo;
      logic       irq_routing_select;
      logic       alarm_two_irq_enable;
      logic       alarm_one_irq_enable;
   } ctrl_t;

   // Status register layout
   typedef struct packed {
      logic       osc_stopped_flag;
      logic [4:0] unused;
      logic       alarm_two_flag;
      logic       alarm_one_flag;
   } status_t;

   // Serial slave states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_SACK,
      ST_TX,
      ST_MACK
   } slave_state_t;

endpackage
`default_nettype wire

// *** verilog/rtc_ctrl_status.sv ***
// Control, status, square wave and two-wire slave port of the real-time clock
`timescale 1ns/1ps
`default_nettype none

module rtc_ctrl_status #(
   parameter int OSC_WATCH = rtc_ctrl_pkg::OSC_WATCH_CYCLES
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic srst,
   // Crystal oscillator clock, twice 32.768 kHz while running
   input  wire logic xtal_clk,
   // Alarm comparison results from the timekeeping logic, xtal_clk domain
   input  wire logic alarm_one_match,
   input  wire logic alarm_two_match,
   // Two-wire bus pins
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // Oscillator run request to the crystal driver
   output logic      osc_run,
   // Interrupt and square wave outputs, active low
   output logic      irq_out_first_n,
   output logic      square_or_irq_second_n
);

   // Control and status state
   rtc_ctrl_pkg::ctrl_t        ctrl_r;
   rtc_ctrl_pkg::status_t      stat_r;
   logic [7:0]                 ptr_r;

   // Serial slave state
   rtc_ctrl_pkg::slave_state_t st_r;
   logic [3:0]                 bit_cnt_r;
   logic [7:0]                 shift_r;
   logic                       addr_phase_r;
   logic                       ptr_phase_r;
   logic                       read_r;
   logic                       sda_oe_r;

   // Pin synchronisers
   logic [1:0]                 scl_sync_r;
   logic [1:0]                 sda_sync_r;
   logic                       scl_d_r;
   logic                       sda_d_r;

   // Oscillator domain state
   logic [1:0]                 xrst_sync_r;
   logic [1:0]                 xrun_sync_r;
   logic [3:0]                 xrate_sync_r;
   logic [rtc_ctrl_pkg::DIV_WIDTH-1:0] div_r;
   logic                       sq_r;
   logic                       a1_tgl_r;
   logic                       a2_tgl_r;

   // Crossings back into mclk
   logic [2:0]                 a1_sync_r;
   logic [2:0]                 a2_sync_r;
   logic [2:0]                 beat_sync_r;
   logic [1:0]                 sq_sync_r;
   logic [$clog2(OSC_WATCH+1)-1:0] watch_r;
   logic                       stopped_r;
   logic                       irq1_n_r;
   logic                       irq2_n_r;

   // ---------------- Oscillator domain ----------------

   // Reset, run request and rate bits brought into the oscillator domain
   always_ff @(posedge xtal_clk)
   begin
      xrst_sync_r  <= {xrst_sync_r[0], srst};
      xrun_sync_r  <= {xrun_sync_r[0], ~ctrl_r.osc_disable_n};
      xrate_sync_r <= {xrate_sync_r[1:0], ctrl_r.rate_select_hi, ctrl_r.rate_select_lo};
   end

   wire        xrst      = xrst_sync_r[1];
   wire        xrun      = xrun_sync_r[1];
   wire [1:0]  xrate     = xrate_sync_r[3:2];
   wire        sec_tick  = xrun && (div_r == {rtc_ctrl_pkg::DIV_WIDTH{1'b1}});

   // Square wave tap selection
   logic sq_nxt;
   always_comb
   begin
      case (xrate)
         rtc_ctrl_pkg::RATE_1HZ: sq_nxt = div_r[rtc_ctrl_pkg::TAP_1HZ];
         rtc_ctrl_pkg::RATE_4K:  sq_nxt = div_r[rtc_ctrl_pkg::TAP_4K];
         rtc_ctrl_pkg::RATE_8K:  sq_nxt = div_r[rtc_ctrl_pkg::TAP_8K];
         default:                sq_nxt = div_r[rtc_ctrl_pkg::TAP_32K];
      endcase
   end

   // Divider counts only while the oscillator is enabled
   always_ff @(posedge xtal_clk)
   begin
      if (xrst)
      begin
         div_r <= '0;
         sq_r  <= 1'b0;
      end
      else
      begin
         if (xrun)
            div_r <= div_r + 1'b1;
         sq_r <= sq_nxt;
      end
   end

   // Alarm match tested once per second, each hit sent as a toggle
   always_ff @(posedge xtal_clk)
   begin
      if (xrst)
      begin
         a1_tgl_r <= 1'b0;
         a2_tgl_r <= 1'b0;
      end
      else
      begin
         if (sec_tick && alarm_one_match)
            a1_tgl_r <= ~a1_tgl_r;
         if (sec_tick && alarm_two_match)
            a2_tgl_r <= ~a2_tgl_r;
      end
   end

   // ---------------- mclk domain crossings ----------------

   // Two stages each, the third stage only serves edge detection
   always_ff @(posedge mclk)
   begin
      a1_sync_r   <= {a1_sync_r[1:0], a1_tgl_r};
      a2_sync_r   <= {a2_sync_r[1:0], a2_tgl_r};
      beat_sync_r <= {beat_sync_r[1:0], div_r[0]};
      sq_sync_r   <= {sq_sync_r[0], sq_r};
      scl_sync_r  <= {scl_sync_r[0], scl_in};
      sda_sync_r  <= {sda_sync_r[0], sda_in};
      scl_d_r     <= scl_sync_r[1];
      sda_d_r     <= sda_sync_r[1];
   end

   wire a1_event  = a1_sync_r[2] ^ a1_sync_r[1];
   wire a2_event  = a2_sync_r[2] ^ a2_sync_r[1];
   wire beat      = beat_sync_r[2] ^ beat_sync_r[1];

   // Watchdog on the divider heartbeat detects a stalled crystal
   always_ff @(posedge mclk)
   begin
      if (srst || beat)
      begin
         watch_r   <= '0;
         stopped_r <= 1'b0;
      end
      else if (watch_r == OSC_WATCH[$bits(watch_r)-1:0])
         stopped_r <= 1'b1;
      else
         watch_r   <= watch_r + 1'b1;
   end

   // ---------------- Bus condition detection ----------------

   wire scl_s     = scl_sync_r[1];
   wire sda_s     = sda_sync_r[1];
   wire scl_rise  = scl_s && !scl_d_r;
   wire scl_fall  = !scl_s && scl_d_r;
   wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
   wire stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;

   // Received byte, address match and register pointer decode
   wire [7:0] rx_byte    = shift_r;
   wire       addr_hit   = (rx_byte[7:1] == rtc_ctrl_pkg::SLAVE_ADDR);
   wire       byte_done  = scl_fall && (bit_cnt_r == rtc_ctrl_pkg::BIT_FULL);
   wire       wr_strobe  = (st_r == rtc_ctrl_pkg::ST_RX) && byte_done
                           && !addr_phase_r && !ptr_phase_r;
   wire       wr_ctrl    = wr_strobe && (ptr_r == rtc_ctrl_pkg::CTRL_OFFSET);
   wire       wr_stat    = wr_strobe && (ptr_r == rtc_ctrl_pkg::STATUS_OFFSET);
   wire [7:0] ptr_inc    = (ptr_r == rtc_ctrl_pkg::PTR_LAST) ? rtc_ctrl_pkg::PTR_RESET
                           : ptr_r + 8'h01;

   // Read data, unused bits are held zero in the registers
   wire [7:0] rd_data    = (ptr_r == rtc_ctrl_pkg::CTRL_OFFSET)   ? ctrl_r :
                           (ptr_r == rtc_ctrl_pkg::STATUS_OFFSET) ? stat_r : 8'h00;

   // ---------------- Serial slave state machine ----------------

   rtc_ctrl_pkg::slave_state_t st_nxt;
   logic [3:0] bit_cnt_nxt;
   logic [7:0] shift_nxt;
   logic [7:0] ptr_nxt;
   logic       addr_phase_nxt;
   logic       ptr_phase_nxt;
   logic       read_nxt;
   logic       sda_oe_nxt;

   always_comb
   begin
      st_nxt         = st_r;
      bit_cnt_nxt    = bit_cnt_r;
      shift_nxt      = shift_r;
      ptr_nxt        = ptr_r;
      addr_phase_nxt = addr_phase_r;
      ptr_phase_nxt  = ptr_phase_r;
      read_nxt       = read_r;
      sda_oe_nxt     = sda_oe_r;
      if (start_det)
      begin
         st_nxt         = rtc_ctrl_pkg::ST_RX;
         bit_cnt_nxt    = '0;
         addr_phase_nxt = 1'b1;
         sda_oe_nxt     = 1'b0;
      end
      else if (stop_det)
      begin
         st_nxt     = rtc_ctrl_pkg::ST_IDLE;
         sda_oe_nxt = 1'b0;
      end
      else
      begin
         case (st_r)
            rtc_ctrl_pkg::ST_RX:
            begin
               // Sample on the rising edge, MSB first
               if (scl_rise && bit_cnt_r != rtc_ctrl_pkg::BIT_FULL)
               begin
                  shift_nxt   = {shift_r[6:0], sda_s};
                  bit_cnt_nxt = bit_cnt_r + 4'h1;
               end
               else if (byte_done)
               begin
                  if (addr_phase_r)
                  begin
                     addr_phase_nxt = 1'b0;
                     read_nxt       = rx_byte[0];
                     ptr_phase_nxt  = !rx_byte[0];
                     st_nxt         = addr_hit ? rtc_ctrl_pkg::ST_SACK
                                               : rtc_ctrl_pkg::ST_IDLE;
                     sda_oe_nxt     = addr_hit;
                  end
                  else
                  begin
                     ptr_nxt       = ptr_phase_r ? rx_byte : ptr_inc;
                     ptr_phase_nxt = 1'b0;
                     st_nxt        = rtc_ctrl_pkg::ST_SACK;
                     sda_oe_nxt    = 1'b1;
                  end
               end
            end
            rtc_ctrl_pkg::ST_SACK:
            begin
               // Hold the acknowledge low through the whole high phase
               if (scl_fall)
               begin
                  bit_cnt_nxt = '0;
                  if (read_r)
                  begin
                     st_nxt     = rtc_ctrl_pkg::ST_TX;
                     shift_nxt  = rd_data;
                     sda_oe_nxt = !rd_data[7];
                  end
                  else
                  begin
                     st_nxt     = rtc_ctrl_pkg::ST_RX;
                     sda_oe_nxt = 1'b0;
                  end
               end
            end
            rtc_ctrl_pkg::ST_TX:
            begin
               // Next bit placed on the falling edge only
               if (scl_fall)
               begin
                  if (bit_cnt_r == rtc_ctrl_pkg::BIT_LAST)
                  begin
                     st_nxt     = rtc_ctrl_pkg::ST_MACK;
                     sda_oe_nxt = 1'b0;
                     ptr_nxt    = ptr_inc;
                  end
                  else
                  begin
                     shift_nxt   = {shift_r[6:0], 1'b0};
                     bit_cnt_nxt = bit_cnt_r + 4'h1;
                     sda_oe_nxt  = !shift_r[6];
                  end
               end
            end
            rtc_ctrl_pkg::ST_MACK:
            begin
               // Acknowledge continues the read, not-acknowledge ends it
               if (scl_rise)
                  read_nxt = !sda_s;
               else if (scl_fall)
               begin
                  bit_cnt_nxt = '0;
                  if (read_r)
                  begin
                     st_nxt     = rtc_ctrl_pkg::ST_TX;
                     shift_nxt  = rd_data;
                     sda_oe_nxt = !rd_data[7];
                  end
                  else
                  begin
                     st_nxt     = rtc_ctrl_pkg::ST_IDLE;
                     sda_oe_nxt = 1'b0;
                  end
               end
            end
            default:
            begin
               st_nxt     = rtc_ctrl_pkg::ST_IDLE;
               sda_oe_nxt = 1'b0;
            end
         endcase
      end
   end

   // Slave state registers, sampled at 200 MHz for both bus speeds
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_r         <= rtc_ctrl_pkg::ST_IDLE;
         bit_cnt_r    <= '0;
         shift_r      <= '0;
         ptr_r        <= rtc_ctrl_pkg::PTR_RESET;
         addr_phase_r <= 1'b0;
         ptr_phase_r  <= 1'b0;
         read_r       <= 1'b0;
         sda_oe_r     <= 1'b0;
      end
      else
      begin
         st_r         <= st_nxt;
         bit_cnt_r    <= bit_cnt_nxt;
         shift_r      <= shift_nxt;
         ptr_r        <= ptr_nxt;
         addr_phase_r <= addr_phase_nxt;
         ptr_phase_r  <= ptr_phase_nxt;
         read_r       <= read_nxt;
         sda_oe_r     <= sda_oe_nxt;
      end
   end

   // ---------------- Control and status registers ----------------

   // Control register, unused bits stay zero
   always_ff @(posedge mclk)
   begin
      if (srst)
         ctrl_r <= rtc_ctrl_pkg::CTRL_RESET;
      else if (wr_ctrl)
         ctrl_r <= rx_byte & rtc_ctrl_pkg::CTRL_WR_MASK;
   end

   // Write-zero clears; a set in the same cycle wins
   wire stop_set = stopped_r || ctrl_r.osc_disable_n;
   wire stop_clr = wr_stat && !rx_byte[rtc_ctrl_pkg::STAT_STOP_BIT];
   wire a2_clr   = wr_stat && !rx_byte[rtc_ctrl_pkg::STAT_ALM2_BIT];
   wire a1_clr   = wr_stat && !rx_byte[rtc_ctrl_pkg::STAT_ALM1_BIT];

   // Sticky status flags
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         stat_r                  <= '0;
         stat_r.osc_stopped_flag <= rtc_ctrl_pkg::STOP_FLAG_RESET;
      end
      else
      begin
         stat_r.osc_stopped_flag <= stop_set | (stat_r.osc_stopped_flag & ~stop_clr);
         stat_r.alarm_two_flag   <= a2_event | (stat_r.alarm_two_flag & ~a2_clr);
         stat_r.alarm_one_flag   <= a1_event | (stat_r.alarm_one_flag & ~a1_clr);
      end
   end

   // ---------------- Interrupt routing ----------------

   wire a1_act  = stat_r.alarm_one_flag & ctrl_r.alarm_one_irq_enable;
   wire a2_act  = stat_r.alarm_two_flag & ctrl_r.alarm_two_irq_enable;
   wire route   = ctrl_r.irq_routing_select;
   wire irq1_n_nxt = !(a1_act || (!route && a2_act));
   wire irq2_n_nxt = route ? !a2_act : sq_sync_r[1];

   // Registered pins, driven low while active
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         irq1_n_r <= 1'b1;
         irq2_n_r <= 1'b1;
      end
      else
      begin
         irq1_n_r <= irq1_n_nxt;
         irq2_n_r <= irq2_n_nxt;
      end
   end

   // Output pins
   assign irq_out_first_n        = irq1_n_r;
   assign square_or_irq_second_n = irq2_n_r;
   assign sda_out                = 1'b0;
   assign sda_oe                 = sda_oe_r;
   assign osc_run                = ~ctrl_r.osc_disable_n;

endmodule // rtc_ctrl_status
`default_nettype wire
